/* File: bwd_cfg.svh */
// Contract
// R1: Downstream port sets received-system-error on fatal/nonfatal message; write one clears.
// R2: Downstream port sets detected-parity-error on any poisoned TLP from below; W1C.
// R3: Received target-abort and master-abort bits always read zero.
// R4: Memory goes downstream when inside either valid memory window.
// R5: Memory goes upstream only when outside both memory windows.
// R6: Memory base holds bits 31:20, resets all ones, low bits taken as zero.
// R7: Memory limit holds bits 31:20, resets zero, low bits taken as ones.
// R8: Prefetch capability nibbles read 0h or 1h, default 1h, loadable only.
// R9: Prefetch base/limit hold bits 31:20; reset ones/zero; low bits zero/ones.
// R10: Prefetch upper words writable and decoded only when capability is 1h.
// R11: I/O upper halves writable and decoded only when their capability is 1h.
// R12: Capability pointer is read-only, defaults 40h, upper bits zero.
// R13: Interrupt line is plain read-write scratch with no effect.
// R14: Interrupt pin read-only, default 01h, loader may write only 00h/01h.
// R15: Master-data-parity-error may set only while poisoned-response enable is one.
// R16: Error-forward enable forwards messages; with command enable sets signaled-system-error.
// R17: ISA alias blocks downstream last 768 bytes per 1 KB; forwards them upstream (code: first 64 KB only).
// R18: VGA enable forwards VGA memory and I/O down, blocks them upstream.
// R19: VGA forwarding needs memory/I/O enables; VGA enable resets zero.
// R20: VGA enable makes the egress port store-and-forward.
// R21: VGA 16-bit decode bit picks 10 or 16 bit VGA I/O decode.
// R22: Invalid I/O window forwards nothing down and everything up (code: with VGA enabled, VGA I/O still goes down, not up).
// R23: With response enabled, poisoned completion or forwarded write sets master parity.
// R24: Decode always uses the current register contents.
`ifndef BWD_CFG_SVH
`define BWD_CFG_SVH
`define BWD_OFF_SEC_STAT 8'h1C
`define BWD_OFF_MEM_WIN 8'h20
`define BWD_OFF_PF_WIN 8'h24
`define BWD_OFF_PF_BASE_HI 8'h28
`define BWD_OFF_PF_TOP_HI 8'h2C
`define BWD_OFF_IO_HI 8'h30
`define BWD_OFF_CAP_PTR 8'h34
`define BWD_OFF_ROM 8'h38
`define BWD_OFF_BRG_CTL 8'h3C
`define BWD_RST_BASE 12'hFFF
`define BWD_RST_TOP 12'h000
`define BWD_RST_IO_BASE 4'hF
`define BWD_RST_IO_TOP 4'h0
`define BWD_RST_CAP 4'h1
`define BWD_CAP_64 4'h1
`define BWD_RST_CAP_PTR 8'h40
`define BWD_RST_INT_PIN 8'h01
`define BWD_BIT_MDPE 24
`define BWD_BIT_RSE 30
`define BWD_BIT_DPE 31
`define BWD_BIT_PERR 16
`define BWD_BIT_SERR 17
`define BWD_BIT_ISA 18
`define BWD_BIT_VGA 19
`define BWD_BIT_VGA16 20
`define BWD_BIT_SBR 22
`define BWD_VGA_MEM_LO 32'h000A_0000
`define BWD_VGA_MEM_HI 32'h000B_FFFF
`define BWD_VGA_IO_A_LO 10'h3B0
`define BWD_VGA_IO_A_HI 10'h3BB
`define BWD_VGA_IO_B_LO 10'h3C0
`define BWD_VGA_IO_B_HI 10'h3DF
`endif

/* File: bwd_pkg.sv */
package bwd_pkg;
	typedef struct packed {
		logic wr;
		logic rd;
		logic init;
		logic [7:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} bwd_cfg_req_t;
	typedef struct packed {
		logic valid;
		logic upstream;
		logic is_io;
		logic [63:0] addr;
	} bwd_dec_req_t;
	typedef struct packed {
		logic err_fatal_nf;
		logic err_any;
		logic poison_rx;
		logic poison_cpl;
		logic poison_wr_fwd;
	} bwd_event_t;
	typedef struct packed {
		logic mem_en;
		logic io_en;
		logic serr_en;
		logic palette_snoop;
	} bwd_cmd_t;
	typedef struct packed {
		logic [3:0] io_cap_b;
		logic [3:0] io_base;
		logic [3:0] io_cap_t;
		logic [3:0] io_top;
		logic [11:0] mem_base;
		logic [11:0] mem_top;
		logic [3:0] pf_cap_b;
		logic [11:0] pf_base;
		logic [3:0] pf_cap_t;
		logic [11:0] pf_top;
		logic [31:0] pf_base_high;
		logic [31:0] pf_top_high;
		logic [15:0] io_base_hi;
		logic [15:0] io_top_hi;
		logic [7:0] cap_ptr;
		logic [7:0] int_line;
		logic [7:0] int_pin;
		logic perr_resp;
		logic serr_fwd;
		logic isa_en;
		logic vga_en;
		logic vga16;
		logic sec_bus_rst;
		logic mdpe;
		logic rse;
		logic dpe;
		logic [31:0] rdata;
		logic rvalid;
		logic dec_valid;
		logic dec_fwd;
		logic err_fwd;
		logic sse;
	} bwd_state_t;
endpackage : bwd_pkg

/* File: bwd_bridge_window_decode_regs.sv */
`timescale 1ns/100ps
`default_nettype none
`include "bwd_cfg.svh"
module bwd_bridge_window_decode_regs (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_is_downstream,
	input wire bwd_pkg::bwd_cfg_req_t i_cfg,
	input wire bwd_pkg::bwd_cmd_t i_cmd,
	input wire bwd_pkg::bwd_event_t i_ev,
	input wire bwd_pkg::bwd_dec_req_t i_dec,
	output logic [31:0] o_cfg_rdata,
	output logic o_cfg_rvalid,
	output logic o_dec_valid,
	output logic o_dec_fwd,
	output logic o_err_fwd,
	output logic o_sig_sys_err,
	output logic o_store_fwd,
	output logic o_sec_bus_rst
);
	bwd_pkg::bwd_state_t s_q;
	bwd_pkg::bwd_state_t s_d;
	logic [31:0] mask;
	logic [31:0] cur;
	logic [31:0] wv;
	logic sel_stat, sel_mem, sel_pf, sel_pbh, sel_pth, sel_ioh, sel_cap, sel_ctl;
	logic pf64_b, pf64_t, io32_b, io32_t;
	logic [63:0] a;
	logic [63:0] pf_lo, pf_hi;
	logic [31:0] io_lo, io_hi;
	logic mem_ok, pf_ok, io_ok, mem_hit, pf_hit, io_hit;
	logic isa_alias, vga_mem, vga_io, io64k;

	assign mask = {{8{i_cfg.be[3]}}, {8{i_cfg.be[2]}}, {8{i_cfg.be[1]}}, {8{i_cfg.be[0]}}};
	assign sel_stat = i_cfg.addr == `BWD_OFF_SEC_STAT;
	assign sel_mem = i_cfg.addr == `BWD_OFF_MEM_WIN;
	assign sel_pf = i_cfg.addr == `BWD_OFF_PF_WIN;
	assign sel_pbh = i_cfg.addr == `BWD_OFF_PF_BASE_HI;
	assign sel_pth = i_cfg.addr == `BWD_OFF_PF_TOP_HI;
	assign sel_ioh = i_cfg.addr == `BWD_OFF_IO_HI;
	assign sel_cap = i_cfg.addr == `BWD_OFF_CAP_PTR;
	assign sel_ctl = i_cfg.addr == `BWD_OFF_BRG_CTL;

	assign pf64_b = s_q.pf_cap_b == `BWD_CAP_64;
	assign pf64_t = s_q.pf_cap_t == `BWD_CAP_64;
	assign io32_b = s_q.io_cap_b == `BWD_CAP_64;
	assign io32_t = s_q.io_cap_t == `BWD_CAP_64;

	// Register read view; reserved bits and ROM base read zero
	always_comb begin
		case (i_cfg.addr)
			`BWD_OFF_SEC_STAT: cur = {s_q.dpe, s_q.rse, 2'b00, 3'b000, s_q.mdpe, 8'h00,
				s_q.io_top, s_q.io_cap_t, s_q.io_base, s_q.io_cap_b}; // [R3]
			`BWD_OFF_MEM_WIN: cur = {s_q.mem_top, 4'h0, s_q.mem_base, 4'h0};
			`BWD_OFF_PF_WIN: cur = {s_q.pf_top, s_q.pf_cap_t, s_q.pf_base, s_q.pf_cap_b};
			`BWD_OFF_PF_BASE_HI: cur = pf64_b ? s_q.pf_base_high : 32'h0000_0000; // [R10]
			`BWD_OFF_PF_TOP_HI: cur = pf64_t ? s_q.pf_top_high : 32'h0000_0000; // [R10]
			`BWD_OFF_IO_HI: cur = {io32_t ? s_q.io_top_hi : 16'h0000,
				io32_b ? s_q.io_base_hi : 16'h0000}; // [R11]
			`BWD_OFF_CAP_PTR: cur = {24'h00_0000, s_q.cap_ptr}; // [R12]
			`BWD_OFF_BRG_CTL: cur = {9'h000, s_q.sec_bus_rst, 1'b0, s_q.vga16, s_q.vga_en,
				s_q.isa_en, s_q.serr_fwd, s_q.perr_resp, s_q.int_pin, s_q.int_line};
			default: cur = 32'h0000_0000;
		endcase
	end

	// Byte-lane merge of write data
	assign wv = (cur & ~mask) | (i_cfg.wdata & mask);

	// Window limits built from current registers every request [R24]
	assign a = i_dec.addr;
	assign pf_lo = {pf64_b ? s_q.pf_base_high : 32'h0000_0000, s_q.pf_base, 20'h00000}; // [R9]
	assign pf_hi = {pf64_t ? s_q.pf_top_high : 32'h0000_0000, s_q.pf_top, 20'hFFFFF}; // [R9]
	assign io_lo = {io32_b ? s_q.io_base_hi : 16'h0000, s_q.io_base, 12'h000}; // [R11]
	assign io_hi = {io32_t ? s_q.io_top_hi : 16'h0000, s_q.io_top, 12'hFFF}; // [R11]
	assign mem_ok = s_q.mem_base <= s_q.mem_top;
	assign pf_ok = pf_lo <= pf_hi;
	assign io_ok = io_lo <= io_hi;
	// Memory window: low 20 bits zero for base, ones for limit [R6] [R7]
	assign mem_hit = mem_ok && (a[63:32] == 32'h0000_0000) && (a[31:20] >= s_q.mem_base)
		&& (a[31:20] <= s_q.mem_top);
	assign pf_hit = pf_ok && (a >= pf_lo) && (a <= pf_hi);
	assign io_hit = io_ok && (a[63:32] == 32'h0000_0000) && (a[31:0] >= io_lo)
		&& (a[31:0] <= io_hi);
	assign io64k = a[63:16] == 48'h0000_0000_0000;
	// Offsets 100h-3FFh of each 1 KB block in the first 64 KB are the ISA aliases [R17]
	assign isa_alias = s_q.isa_en && io64k && (a[9:8] != 2'b00);
	assign vga_mem = (a[63:32] == 32'h0000_0000) && (a[31:0] >= `BWD_VGA_MEM_LO)
		&& (a[31:0] <= `BWD_VGA_MEM_HI); // [R18]
	// 10-bit decode ignores bits 15:10; 16-bit decode needs them zero [R21]
	assign vga_io = io64k && (!s_q.vga16 || a[15:10] == 6'h00)
		&& (((a[9:0] >= `BWD_VGA_IO_A_LO) && (a[9:0] <= `BWD_VGA_IO_A_HI))
		|| ((a[9:0] >= `BWD_VGA_IO_B_LO) && (a[9:0] <= `BWD_VGA_IO_B_HI)));

	always_comb begin
		logic vm, vi, down, up;
		down = 1'b0;
		up = 1'b0;
		s_d = s_q;
		vm = s_q.vga_en && i_cmd.mem_en && vga_mem; // [R19]
		vi = s_q.vga_en && i_cmd.io_en && vga_io; // [R19]
		// Downstream: VGA wins over windows and ISA alias [R18]
		if (i_dec.is_io) begin
			down = vi || (i_cmd.io_en && io_hit && !isa_alias); // [R17] [R22]
			up = !vi && (!io_ok || !io_hit || (isa_alias && i_cmd.io_en)); // [R17] [R22]
		end else begin
			down = vm || mem_hit || pf_hit; // [R4]
			up = !vm && !mem_hit && !pf_hit; // [R5]
		end
		s_d.dec_valid = i_dec.valid;
		s_d.dec_fwd = i_dec.valid && (i_dec.upstream ? up : down);
		s_d.rvalid = i_cfg.rd;
		s_d.rdata = i_cfg.rd ? cur : s_q.rdata;
		s_d.err_fwd = s_q.serr_fwd && i_ev.err_any; // [R16]
		s_d.sse = s_q.serr_fwd && i_cmd.serr_en && i_ev.err_any; // [R16]
		if (i_cfg.wr) begin
			if (sel_stat) begin
				s_d.io_base = wv[7:4];
				s_d.io_top = wv[15:12];
				if (i_cfg.init) begin
					s_d.io_cap_b = wv[3:0];
					s_d.io_cap_t = wv[11:8];
					s_d.mdpe = wv[`BWD_BIT_MDPE];
					s_d.rse = wv[`BWD_BIT_RSE];
					s_d.dpe = wv[`BWD_BIT_DPE];
				end else begin
					// Write one clears
					s_d.mdpe = s_q.mdpe && !(i_cfg.be[3] && i_cfg.wdata[`BWD_BIT_MDPE]);
					s_d.rse = s_q.rse && !(i_cfg.be[3] && i_cfg.wdata[`BWD_BIT_RSE]); // [R1]
					s_d.dpe = s_q.dpe && !(i_cfg.be[3] && i_cfg.wdata[`BWD_BIT_DPE]); // [R2]
				end
			end
			if (sel_mem) begin
				s_d.mem_base = wv[15:4]; // [R6]
				s_d.mem_top = wv[31:20]; // [R7]
			end
			if (sel_pf) begin
				s_d.pf_base = wv[15:4]; // [R9]
				s_d.pf_top = wv[31:20]; // [R9]
				// Capability nibbles only from the loader, 0h or 1h [R8]
				if (i_cfg.init && wv[3:1] == 3'b000) begin
					s_d.pf_cap_b = wv[3:0];
				end
				if (i_cfg.init && wv[19:17] == 3'b000) begin
					s_d.pf_cap_t = wv[19:16];
				end
			end
			if (sel_pbh && pf64_b) begin
				s_d.pf_base_high = wv; // [R10]
			end
			if (sel_pth && pf64_t) begin
				s_d.pf_top_high = wv; // [R10]
			end
			if (sel_ioh && io32_b) begin
				s_d.io_base_hi = wv[15:0]; // [R11]
			end
			if (sel_ioh && io32_t) begin
				s_d.io_top_hi = wv[31:16]; // [R11]
			end
			if (sel_cap && i_cfg.init) begin
				s_d.cap_ptr = wv[7:0]; // [R12]
			end
			if (sel_ctl) begin
				s_d.int_line = wv[7:0]; // [R13]
				if (i_cfg.init && wv[15:9] == 7'h00) begin
					s_d.int_pin = wv[15:8]; // [R14]
				end
				s_d.perr_resp = wv[`BWD_BIT_PERR];
				s_d.serr_fwd = wv[`BWD_BIT_SERR];
				s_d.isa_en = wv[`BWD_BIT_ISA];
				s_d.vga_en = wv[`BWD_BIT_VGA];
				s_d.vga16 = wv[`BWD_BIT_VGA16];
				s_d.sec_bus_rst = wv[`BWD_BIT_SBR];
			end
		end
		// Hardware sets after clears so a same-cycle event is kept
		if (i_is_downstream && i_ev.err_fatal_nf) begin
			s_d.rse = 1'b1; // [R1]
		end
		if (i_is_downstream && i_ev.poison_rx) begin
			s_d.dpe = 1'b1; // [R2]
		end
		if (s_q.perr_resp && (i_ev.poison_cpl || i_ev.poison_wr_fwd)) begin
			s_d.mdpe = 1'b1; // [R15] [R23]
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			s_q <= '0;
			s_q.io_cap_b <= `BWD_RST_CAP;
			s_q.io_cap_t <= `BWD_RST_CAP;
			s_q.io_base <= `BWD_RST_IO_BASE;
			s_q.io_top <= `BWD_RST_IO_TOP;
			s_q.mem_base <= `BWD_RST_BASE; // [R6]
			s_q.mem_top <= `BWD_RST_TOP; // [R7]
			s_q.pf_cap_b <= `BWD_RST_CAP; // [R8]
			s_q.pf_cap_t <= `BWD_RST_CAP; // [R8]
			s_q.pf_base <= `BWD_RST_BASE; // [R9]
			s_q.pf_top <= `BWD_RST_TOP; // [R9]
			s_q.cap_ptr <= `BWD_RST_CAP_PTR; // [R12]
			s_q.int_pin <= `BWD_RST_INT_PIN; // [R14]
		end else begin
			s_q <= s_d;
		end
	end

	assign o_cfg_rdata = s_q.rdata;
	assign o_cfg_rvalid = s_q.rvalid;
	assign o_dec_valid = s_q.dec_valid;
	assign o_dec_fwd = s_q.dec_fwd;
	assign o_err_fwd = s_q.err_fwd;
	assign o_sig_sys_err = s_q.sse;
	// Cut-through disabled while VGA forwarding is on [R20]
	assign o_store_fwd = s_q.vga_en;
	assign o_sec_bus_rst = s_q.sec_bus_rst;
endmodule : bwd_bridge_window_decode_regs
`default_nettype wire

/* File: bwd_props.sv */
`timescale 1ns/100ps
`default_nettype none
module bwd_props (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire bwd_pkg::bwd_cfg_req_t i_cfg,
	input wire bwd_pkg::bwd_cmd_t i_cmd,
	input wire bwd_pkg::bwd_event_t i_ev,
	input wire bwd_pkg::bwd_dec_req_t i_dec,
	input wire logic [31:0] o_cfg_rdata,
	input wire logic o_cfg_rvalid,
	input wire logic o_dec_valid,
	input wire logic o_dec_fwd,
	input wire logic o_err_fwd,
	input wire logic o_sig_sys_err,
	input wire logic o_store_fwd
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	logic vga_m;
	// Store-forward output mirrors the VGA enable bit, so it stands in for it
	assign vga_m = i_dec.valid && !i_dec.is_io && i_cmd.mem_en && o_store_fwd
		&& i_dec.addr >= 64'hA_0000 && i_dec.addr <= 64'hB_FFFF;
	a_dec_one_cycle: assert property (i_dec.valid |=> o_dec_valid)
		else $error("decode answer missing");
	a_fwd_only_valid: assert property (!o_dec_valid |-> !o_dec_fwd)
		else $error("forward without decode");
	a_vga_down: assert property (vga_m && !i_dec.upstream |=> o_dec_fwd)
		else $error("vga memory not sent down");
	a_vga_up_block: assert property (vga_m && i_dec.upstream |=> !o_dec_fwd)
		else $error("vga memory sent up");
	a_err_fwd_cause: assert property (o_err_fwd |-> $past(i_ev.err_any))
		else $error("message forwarded without cause");
	a_sse_cause: assert property (o_sig_sys_err |-> $past(i_cmd.serr_en && i_ev.err_any))
		else $error("system error without enable");
	a_cap_ptr_read: assert property (i_cfg.rd && i_cfg.addr == 8'h34
		|=> o_cfg_rdata == 32'h0000_0040) else $error("capability pointer wrong");
	a_read_answer: assert property (o_cfg_rvalid == $past(i_cfg.rd))
		else $error("read answer not one cycle after strobe");
	a_abort_bits_zero: assert property (i_cfg.rd && i_cfg.addr == 8'h1C
		|=> o_cfg_rdata[29:28] == 2'h0) else $error("abort bits set");
	a_vga_to_store: assert property (i_cfg.wr && i_cfg.addr == 8'h3C && i_cfg.be[2]
		|=> o_store_fwd == $past(i_cfg.wdata[19])) else $error("store mode stale");
endmodule : bwd_props
bind bwd_bridge_window_decode_regs bwd_props i_props (.i_clock(i_clock), .i_rst(i_rst),
	.i_cfg(i_cfg), .i_cmd(i_cmd), .i_ev(i_ev), .i_dec(i_dec), .o_cfg_rdata(o_cfg_rdata),
	.o_cfg_rvalid(o_cfg_rvalid),
	.o_dec_valid(o_dec_valid), .o_dec_fwd(o_dec_fwd), .o_err_fwd(o_err_fwd),
	.o_sig_sys_err(o_sig_sys_err), .o_store_fwd(o_store_fwd));
`default_nettype wire

/* File: bwd_far_model.sv */
`timescale 1ns/100ps
`default_nettype none
module bwd_far_model (
	input wire logic i_clock,
	input wire logic [4:0] i_fire,
	output var bwd_pkg::bwd_event_t o_ev
);
	// Devices below send each message as a one-cycle pulse after the edge
	initial o_ev = '0;
	always @(posedge i_clock) begin
		o_ev <= #1 bwd_pkg::bwd_event_t'(i_fire);
	end
endmodule : bwd_far_model
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	typedef struct packed {logic up; logic io; logic [31:0] addr; logic fwd;} bwd_row_t;
	logic i_clock = 1'h0;
	logic i_rst = 1'h1;
	bwd_pkg::bwd_cfg_req_t cfg = '0;
	bwd_pkg::bwd_cmd_t cmd = 4'h0;
	bwd_pkg::bwd_dec_req_t dec = '0;
	bwd_pkg::bwd_event_t ev;
	logic [4:0] fire = 5'h00;
	logic [31:0] rdata;
	logic dvalid, dfwd, efwd, sse;
	logic rvalid, store, sbr;
	int bad_count = 0;
	int cmp_count = 0;
	bwd_row_t rows [13] = '{
		'{1'h0, 1'h0, 32'h1000_0000, 1'h1},
		'{1'h0, 1'h0, 32'h1FFF_FFFF, 1'h1},
		'{1'h0, 1'h0, 32'h0FFF_FFFF, 1'h0},
		'{1'h1, 1'h0, 32'h1000_0000, 1'h0},
		'{1'h1, 1'h0, 32'h2000_0000, 1'h1},
		'{1'h0, 1'h0, 32'h000A_0000, 1'h1},
		'{1'h1, 1'h0, 32'h000B_FFFF, 1'h0},
		'{1'h0, 1'h1, 32'h0000_1000, 1'h1},
		'{1'h0, 1'h1, 32'h0000_1100, 1'h0},
		'{1'h1, 1'h1, 32'h0000_1100, 1'h1},
		'{1'h1, 1'h1, 32'h0000_03B0, 1'h0},
		'{1'h0, 1'h1, 32'h0000_07C0, 1'h1},
		'{1'h1, 1'h1, 32'h0000_5000, 1'h1}};
	always #2.5 i_clock = ~i_clock;
	bwd_far_model i_far (.i_clock(i_clock), .i_fire(fire), .o_ev(ev));
	bwd_bridge_window_decode_regs i_dut (.i_clock(i_clock), .i_rst(i_rst),
		.i_is_downstream(1'h1), .i_cfg(cfg), .i_cmd(cmd), .i_ev(ev), .i_dec(dec),
		.o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid), .o_dec_valid(dvalid), .o_dec_fwd(dfwd),
		.o_err_fwd(efwd), .o_sig_sys_err(sse), .o_store_fwd(store), .o_sec_bus_rst(sbr));
	task tally_and_finish;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : tally_and_finish
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Strobe stands exactly one cycle, launched just after the edge
	task acc(input logic w, input logic ini, input logic [7:0] a, input logic [3:0] b,
		input logic [31:0] d);
		@(posedge i_clock);
		#1;
		cfg = {w, ~w, ini, a, b, d};
		@(posedge i_clock);
		#1;
		cfg = '0;
	endtask : acc
	task rdchk(input logic [7:0] a, input logic [31:0] exp);
		acc(1'h0, 1'h0, a, 4'hF, 32'h0);
		chk(rdata, exp);
		chk({31'h0, rvalid}, 32'h1);
	endtask : rdchk
	task dchk(input bwd_row_t r);
		@(posedge i_clock);
		#1;
		dec = {1'h1, r.up, r.io, 32'h0, r.addr};
		@(posedge i_clock);
		#1;
		dec = '0;
		chk({dvalid, dfwd}, {1'h1, r.fwd});
	endtask : dchk
	// Far side needs one cycle to launch, the block one more to take it
	task evt(input logic [4:0] f);
		@(posedge i_clock);
		#1;
		fire = f;
		@(posedge i_clock);
		#1;
		fire = 5'h00;
		@(posedge i_clock);
		#1;
	endtask : evt
	initial begin
		#50000;
		bad_count++;
		tally_and_finish;
	end
	initial begin
		repeat (5) @(posedge i_clock);
		#1 i_rst = 1'h0;
		rdchk(8'h20, 32'h0000_FFF0);
		rdchk(8'h24, 32'h0001_FFF1);
		rdchk(8'h34, 32'h0000_0040);
		rdchk(8'h3C, 32'h0000_0100);
		rdchk(8'h1C, 32'h0000_01F1);
		cmd = 4'hE;
		acc(1'h1, 1'h0, 8'h20, 4'hF, 32'h1FF0_1000);
		acc(1'h1, 1'h0, 8'h1C, 4'hF, 32'h0000_2010);
		acc(1'h1, 1'h0, 8'h3C, 4'hF, 32'h000E_FF55);
		acc(1'h1, 1'h0, 8'h34, 4'hF, 32'hFFFF_FFFF);
		rdchk(8'h34, 32'h0000_0040);
		rdchk(8'h3C, 32'h000E_0155);
		for (int k = 0; k < 13; k++) dchk(rows[k]);
		evt(5'h04);
		rdchk(8'h1C, 32'h8000_2111);
		evt(5'h10);
		rdchk(8'h1C, 32'hC000_2111);
		evt(5'h02);
		rdchk(8'h1C, 32'hC000_2111);
		acc(1'h1, 1'h0, 8'h1C, 4'h8, 32'hC000_0000);
		rdchk(8'h1C, 32'h0000_2111);
		evt(5'h08);
		chk({efwd, sse}, 2'h3);
		acc(1'h1, 1'h0, 8'h3C, 4'h4, 32'h0001_0000);
		evt(5'h02);
		rdchk(8'h1C, 32'h0100_2111);
		acc(1'h1, 1'h0, 8'h28, 4'hF, 32'hFFFF_FFFF);
		rdchk(8'h28, 32'hFFFF_FFFF);
		acc(1'h1, 1'h1, 8'h24, 4'hF, 32'h0);
		rdchk(8'h28, 32'h0);
		acc(1'h1, 1'h0, 8'h3C, 4'h4, 32'h0058_0000);
		chk({sbr, store}, 2'h3);
		dchk('{1'h0, 1'h1, 32'h0000_07C0, 1'h0});
		dchk('{1'h0, 1'h1, 32'h0000_03C0, 1'h1});
		// Limit below base: window closed
		acc(1'h1, 1'h0, 8'h1C, 4'h2, 32'h0000_0000);
		dchk('{1'h1, 1'h1, 32'h0000_1000, 1'h1});
		dchk('{1'h0, 1'h1, 32'h0000_1000, 1'h0});
		i_rst = 1'h1;
		repeat (2) @(posedge i_clock);
		#1;
		chk({sbr, store}, 2'h0);
		i_rst = 1'h0;
		rdchk(8'h20, 32'h0000_FFF0);
		rdchk(8'h1C, 32'h0000_01F1);
		tally_and_finish;
	end
endmodule : tb_top
`default_nettype wire
